/* File: scan_engine_host_control.sv */
// scan engine host control: trigger sessions, serial port, indicators, registers
//
// Operation
// RULE1 - trigger low ten ms starts session
// RULE2 - after good decode, wait for release
// RULE3 - release during scan aborts decoding at once
// RULE4 - only fresh trigger assertion starts new session
// RULE5 - host spaces triggers over fifty ms
// RULE6 - good read output high 300 ms
// RULE7 - low power flag high while sleeping
// RULE8 - wake input behaves exactly like trigger
// RULE9 - baud selectable from 1200 to 115200
// RULE10 - no hardware or software flow control
// RULE11 - reset default 9600 baud, 8N1
// RULE12 - beeper pwm for power-up and good read
// RULE13 - standard async framing, lsb first
// RULE14 - synchronise triggers, count low time
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scan_engine_host_control import scan_engine_pkg::*; #(
    parameter logic [CNT_W-1:0] TRIG_MIN_CYC_P  = CNT_W'(TRIG_MIN_CYC),
    parameter logic [CNT_W-1:0] GOOD_READ_CYC_P = CNT_W'(GOOD_READ_CYC),
    parameter logic [CNT_W-1:0] BEEP_CYC_P      = CNT_W'(BEEP_CYC)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    input  wire logic        scan_trigger_n,
    input  wire logic        wake_n,
    input  wire logic        decode_good,
    output var  logic        scan_active,
    output var  logic        scan_abort,
    input  wire logic        serial_rx,
    output var  logic        serial_tx,
    output var  logic        low_power_flag_out,
    output var  logic        beeper_pwm_out,
    output var  logic        good_read_out,
    output var  logic        irq
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        session_state_t   st;
        logic             armed;
        logic             abort_p;
        logic [2:0]       baud_sel;
        logic             lp_req;
        logic [CNT_W-1:0] gr_cnt;
        logic [CNT_W-1:0] beep_cnt;
        logic [DIV_W-1:0] tone_cnt;
        logic             tone;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]      rdata;
        logic             tx_valid;
        logic [7:0]       tx_data;
        logic [7:0]       rx_byte;
        logic             rx_full;
    } core_t;

    core_t s_reg;
    core_t s_next;

    uart_if u ();

    logic trig_q;
    logic wake_q;
    logic trig_act;
    logic good_acc;
    logic start_ev;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    // -------------------------------------------------------------------
    // trigger qualifiers
    // -------------------------------------------------------------------
    trig_qual #(.MIN_CYC(TRIG_MIN_CYC_P)) trig_q_i (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_n    (scan_trigger_n),
        .asserted (trig_q)
    );

    trig_qual #(.MIN_CYC(TRIG_MIN_CYC_P)) wake_q_i (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_n    (wake_n),
        .asserted (wake_q)
    );

    // wake acts as a second trigger source
    assign trig_act = trig_q | wake_q;                             // [RULE8]

    // -------------------------------------------------------------------
    // serial port
    // -------------------------------------------------------------------
    serial_port port_i (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .u         (u.port),
        .serial_rx (serial_rx),
        .serial_tx (serial_tx)
    );

    assign u.baud_div = baud_div(s_reg.baud_sel);                  // [RULE9]
    assign u.tx_valid = s_reg.tx_valid;
    assign u.tx_data  = s_reg.tx_data;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    assign good_acc = (s_reg.st == ST_SCAN) && trig_act && decode_good;
    assign start_ev = trig_act && ((s_reg.st == ST_SLEEP) || ((s_reg.st == ST_IDLE) && s_reg.armed));

    always_comb begin
        s_next          = s_reg;
        s_next.abort_p  = 1'b0;
        s_next.tx_valid = 1'b0;
        s_next.rdata    = '0;
        irq_set         = '0;
        irq_clr         = '0;

        if (!trig_act) begin
            s_next.armed = 1'b1;                                   // [RULE4]
        end

        unique case (s_reg.st)
            ST_IDLE: begin
                if (trig_act && s_reg.armed) begin
                    s_next.st    = ST_SCAN;                        // [RULE1]
                    s_next.armed = 1'b0;                           // [RULE4]
                end else if (s_reg.lp_req && !trig_act) begin
                    s_next.st = ST_SLEEP;                          // [RULE7]
                end
            end
            ST_SCAN: begin
                if (!trig_act) begin
                    s_next.st      = ST_IDLE;                      // [RULE3]
                    s_next.abort_p = 1'b1;
                end else if (decode_good) begin
                    s_next.st = ST_HOLD;                           // [RULE2]
                end
            end
            ST_HOLD: begin
                if (!trig_act) begin
                    s_next.st = ST_IDLE;                           // [RULE2]
                end
            end
            ST_SLEEP: begin
                if (trig_act) begin
                    s_next.st     = ST_SCAN;                       // [RULE8]
                    s_next.armed  = 1'b0;
                    s_next.lp_req = 1'b0;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase

        // good read indicator and beeper
        if (good_acc) begin
            s_next.gr_cnt = GOOD_READ_CYC_P;                       // [RULE6]
        end else if (s_reg.gr_cnt != '0) begin
            s_next.gr_cnt = s_reg.gr_cnt - 1'b1;
        end
        if (good_acc || (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_BEEP_BIT])) begin
            s_next.beep_cnt = BEEP_CYC_P;                          // [RULE12]
        end else if (s_reg.beep_cnt != '0) begin
            s_next.beep_cnt = s_reg.beep_cnt - 1'b1;
        end
        if (s_reg.beep_cnt == '0) begin
            s_next.tone     = 1'b0;
            s_next.tone_cnt = '0;
        end else if (s_reg.tone_cnt == DIV_W'(BEEP_HALF_CYC - 1)) begin
            s_next.tone     = !s_reg.tone;                         // [RULE12]
            s_next.tone_cnt = '0;
        end else begin
            s_next.tone_cnt = s_reg.tone_cnt + 1'b1;
        end

        // received bytes overwrite, there is no way to pause the host
        if (u.rx_valid) begin
            s_next.rx_byte = u.rx_data;                            // [RULE10]
            s_next.rx_full = 1'b1;
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    s_next.baud_sel = reg_wdata[CTRL_BAUD_LSB +: 3];   // [RULE9]
                    s_next.lp_req   = reg_wdata[CTRL_LP_BIT];
                end
                ADDR_TXDATA: begin
                    s_next.tx_valid = u.tx_ready;                  // [RULE10]
                    s_next.tx_data  = reg_wdata[7:0];
                end
                ADDR_IRQ_STAT: irq_clr = reg_wdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: s_next.irq_mask = reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        // register reads, data valid in the following cycle only
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL:     s_next.rdata = 32'({s_reg.lp_req, s_reg.baud_sel});
                ADDR_STATUS:   s_next.rdata = 32'({s_reg.rx_full, !u.tx_ready,
                                                   s_reg.st == ST_SLEEP, s_reg.st});
                ADDR_RXDATA: begin
                    s_next.rdata   = 32'(s_reg.rx_byte);
                    s_next.rx_full = u.rx_valid;
                end
                ADDR_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
                ADDR_IRQ_MASK: s_next.rdata = 32'(s_reg.irq_mask);
                default:       s_next.rdata = '0;
            endcase
        end

        // sticky interrupt status, a new event wins over a clear
        irq_set[IRQ_START_BIT] = start_ev;
        irq_set[IRQ_GOOD_BIT]  = good_acc;
        irq_set[IRQ_ABORT_BIT] = (s_reg.st == ST_SCAN) && !trig_act;
        irq_set[IRQ_RX_BIT]    = u.rx_valid;
        s_next.irq_stat        = (s_reg.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: ST_IDLE, baud_sel: BAUD_SEL_RESET, beep_cnt: BEEP_CYC_P,
                       irq_mask: IRQ_MASK_RESET, default: '0};     // [RULE11]
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign reg_rdata          = s_reg.rdata;
    assign scan_active        = (s_reg.st == ST_SCAN);
    assign scan_abort         = s_reg.abort_p;
    assign low_power_flag_out = (s_reg.st == ST_SLEEP);            // [RULE7]
    assign beeper_pwm_out     = s_reg.tone;
    assign good_read_out      = (s_reg.gr_cnt != '0);              // [RULE6]
    assign irq                = |(s_reg.irq_stat & s_reg.irq_mask);

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_START_FRESH: assert property (ce && s_reg.st == ST_IDLE && trig_act && !s_reg.armed |=> s_reg.st != ST_SCAN) // [RULE4]
        else $error("session started without fresh trigger");
    AST_START_QUAL: assert property (ce && s_reg.st == ST_IDLE && trig_act && s_reg.armed |=> scan_active) // [RULE1]
        else $error("qualified trigger did not start a session");
    AST_ABORT: assert property (ce && scan_active && !trig_act |=> scan_abort && s_reg.st == ST_IDLE) // [RULE3]
        else $error("release during scan did not abort");
    AST_HOLD: assert property (ce && s_reg.st == ST_HOLD && trig_act |=> s_reg.st == ST_HOLD) // [RULE2]
        else $error("held trigger left the wait state");
    AST_GOOD_LOAD: assert property (ce && good_acc |=> good_read_out && s_reg.gr_cnt == GOOD_READ_CYC_P && s_reg.st == ST_HOLD) // [RULE6]
        else $error("good read did not load its pulse");
    AST_GOOD_FALL: assert property ($fell(good_read_out) |-> $past(s_reg.gr_cnt) == 1) // [RULE6]
        else $error("good read pulse ended early");
    AST_SLEEP_FLAG: assert property (ce && s_reg.st == ST_IDLE && s_reg.lp_req && !trig_act |=> low_power_flag_out) // [RULE7]
        else $error("low power flag not raised on sleep");
    AST_WAKE: assert property (ce && low_power_flag_out && wake_q |=> scan_active && !low_power_flag_out) // [RULE8]
        else $error("wake did not start a session");
    AST_BAUD_RESET: assert property ($rose(rst_n) |-> u.baud_div == baud_div(BAUD_SEL_RESET)) // [RULE11]
        else $error("baud rate not at default after reset");
    AST_TX_NO_STALL: assert property (ce && reg_wr && reg_addr == ADDR_TXDATA && u.tx_ready |=> u.tx_valid) // [RULE10]
        else $error("byte write to idle transmitter was lost");
    AST_BEEP_GOOD: assert property (ce && good_acc |=> s_reg.beep_cnt == BEEP_CYC_P) // [RULE12]
        else $error("good read did not start the beeper");

    COV_SESSION: cover property (start_ev ##1 scan_active);
    COV_ABORT:   cover property (scan_abort);
    COV_GOOD:    cover property (good_acc ##1 good_read_out);
    COV_SLEEP:   cover property (low_power_flag_out ##1 !low_power_flag_out);
endmodule
`default_nettype wire

/* File: scan_engine_pkg.sv */
// constants, types and register map of the scan engine host control block
package scan_engine_pkg;

    // -------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------
    localparam int CLK_KHZ       = 200_000;
    localparam int TRIG_MIN_MS   = 10;
    localparam int TRIG_MIN_CYC  = TRIG_MIN_MS * CLK_KHZ;
    localparam int GOOD_READ_MS  = 300;
    localparam int GOOD_READ_CYC = GOOD_READ_MS * CLK_KHZ;
    localparam int BEEP_MS       = 100;
    localparam int BEEP_CYC      = BEEP_MS * CLK_KHZ;
    localparam int BEEP_TONE_HZ  = 2700;
    localparam int BEEP_HALF_CYC = (CLK_KHZ * 500) / BEEP_TONE_HZ;
    localparam int CNT_W         = 27;
    localparam int DIV_W         = 18;

    // -------------------------------------------------------------------
    // serial framing and baud table
    // -------------------------------------------------------------------
    localparam int DATA_BITS  = 8;
    localparam int FRAME_BITS = DATA_BITS + 2;
    localparam int BAUD_TABLE [0:7] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    localparam logic [2:0] BAUD_SEL_RESET = 3'h3;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_TXDATA   = 8'h08;
    localparam logic [7:0] ADDR_RXDATA   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    localparam int CTRL_BAUD_LSB = 0;
    localparam int CTRL_LP_BIT   = 3;
    localparam int CTRL_BEEP_BIT = 4;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LP_BIT    = 4;
    localparam int STAT_TXBSY_BIT = 5;
    localparam int STAT_RXFUL_BIT = 6;

    localparam int IRQ_W         = 4;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_GOOD_BIT  = 1;
    localparam int IRQ_ABORT_BIT = 2;
    localparam int IRQ_RX_BIT    = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SCAN  = 4'h2,
        ST_HOLD  = 4'h4,
        ST_SLEEP = 4'h8
    } session_state_t;

    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
        baud_div = DIV_W'((CLK_KHZ * 1000) / BAUD_TABLE[sel]);
    endfunction

endpackage

/* File: uart_if.sv */
// byte stream and baud setting between the control core and the serial port
`timescale 1ns/1ps
`default_nettype none
interface uart_if import scan_engine_pkg::*; ();
    logic [DIV_W-1:0] baud_div;
    logic             tx_valid;
    logic             tx_ready;
    logic [7:0]       tx_data;
    logic             rx_valid;
    logic [7:0]       rx_data;

    modport ctrl (output baud_div, tx_valid, tx_data, input tx_ready, rx_valid, rx_data);
    modport port (input baud_div, tx_valid, tx_data, output tx_ready, rx_valid, rx_data);
endinterface
`default_nettype wire

/* File: trig_qual.sv */
// synchroniser and minimum-low-time qualifier for an active-low trigger pin
`timescale 1ns/1ps
`default_nettype none
module trig_qual import scan_engine_pkg::*; #(
    parameter logic [CNT_W-1:0] MIN_CYC = CNT_W'(TRIG_MIN_CYC)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin_n,
    output var  logic asserted
);
    typedef struct packed {
        logic             s1;
        logic             s2;
        logic [CNT_W-1:0] cnt;
        logic             asserted;
    } qual_t;

    qual_t s_reg;
    qual_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin_n;
        s_next.s2 = s_reg.s1;
        if (s_reg.s2) begin
            s_next.cnt      = '0;                                  // [RULE3]
            s_next.asserted = 1'b0;
        end else if (s_reg.cnt < MIN_CYC - 1'b1) begin
            s_next.cnt = s_reg.cnt + 1'b1;                         // [RULE14]
        end else begin
            s_next.asserted = 1'b1;                                // [RULE1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{s1: 1'b1, s2: 1'b1, cnt: '0, asserted: 1'b0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign asserted = s_reg.asserted;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_QUAL_MIN_LOW: assert property ($rose(asserted) |-> $past(s_reg.cnt) == MIN_CYC - 1'b1 && !$past(s_reg.s2)) // [RULE1]
        else $error("trigger qualified before minimum low time");
    AST_QUAL_RELEASE: assert property (ce && s_reg.s2 |=> !asserted) // [RULE14]
        else $error("qualified trigger did not drop on release");
endmodule
`default_nettype wire

/* File: serial_port.sv */
// asynchronous serial transmitter and receiver, 8 data bits, no parity, 1 stop
`timescale 1ns/1ps
`default_nettype none
module serial_port import scan_engine_pkg::*; (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    uart_if.port      u,
    input  wire logic serial_rx,
    output var  logic serial_tx
);
    typedef struct packed {
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0]       tx_bits;
        logic [9:0]       tx_sh;
        logic             tx_busy;
        logic             tx_line;
        logic [DIV_W-1:0] rx_cnt;
        logic [3:0]       rx_bits;
        logic [7:0]       rx_sh;
        logic             rx_busy;
        logic             rx_in;
        logic             rx_prev;
        logic             rx_valid;
        logic [7:0]       rx_data;
    } port_t;

    port_t s_reg;
    port_t s_next;

    always_comb begin
        s_next          = s_reg;
        s_next.rx_in    = serial_rx;
        s_next.rx_prev  = s_reg.rx_in;
        s_next.rx_valid = 1'b0;
        // transmitter: start bit, data lsb first, stop bit
        if (!s_reg.tx_busy && u.tx_valid) begin
            s_next.tx_sh   = {1'b1, u.tx_data, 1'b0};              // [RULE13]
            s_next.tx_busy = 1'b1;
            s_next.tx_cnt  = '0;
            s_next.tx_bits = '0;
            s_next.tx_line = 1'b0;
        end else if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt == u.baud_div - 1'b1) begin
                s_next.tx_cnt = '0;
                if (s_reg.tx_bits == 4'(FRAME_BITS - 1)) begin
                    s_next.tx_busy = 1'b0;
                    s_next.tx_line = 1'b1;
                end else begin
                    s_next.tx_bits = s_reg.tx_bits + 1'b1;
                    s_next.tx_sh   = {1'b1, s_reg.tx_sh[9:1]};
                    s_next.tx_line = s_reg.tx_sh[1];
                end
            end else begin
                s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
            end
        end
        // receiver: sample each bit in its middle
        if (!s_reg.rx_busy) begin
            if (s_reg.rx_prev && !s_reg.rx_in) begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt  = u.baud_div >> 1;
                s_next.rx_bits = '0;
            end
        end else if (s_reg.rx_cnt == u.baud_div - 1'b1) begin
            s_next.rx_cnt  = '0;
            s_next.rx_bits = s_reg.rx_bits + 1'b1;
            if (s_reg.rx_bits == 4'h0) begin
                s_next.rx_busy = !s_reg.rx_in;
            end else if (s_reg.rx_bits == 4'(FRAME_BITS - 1)) begin
                s_next.rx_busy  = 1'b0;
                s_next.rx_valid = s_reg.rx_in;
                s_next.rx_data  = s_reg.rx_sh;
            end else begin
                s_next.rx_sh = {s_reg.rx_in, s_reg.rx_sh[7:1]};    // [RULE13]
            end
        end else begin
            s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{tx_line: 1'b1, tx_sh: 10'h3FF, rx_in: 1'b1, rx_prev: 1'b1, default: '0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign serial_tx  = s_reg.tx_line;
    assign u.tx_ready = !s_reg.tx_busy;                            // [RULE10]
    assign u.rx_valid = s_reg.rx_valid;
    assign u.rx_data  = s_reg.rx_data;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_TX_START_BIT: assert property (ce && u.tx_valid && u.tx_ready |=> !serial_tx && s_reg.tx_busy) // [RULE13]
        else $error("start bit not sent after accepting a byte");
    AST_TX_IDLE_HIGH: assert property (!s_reg.tx_busy |-> serial_tx) // [RULE13]
        else $error("serial line not high while idle");
endmodule
`default_nettype wire

/* File: host_uart_model.sv */
// host side serial partner: 8N1 receiver and transmitter, no flow control
`timescale 1ns/1ps
`default_nettype none
module host_uart_model #(parameter int BIT_CYC = 1736) (
    input  wire logic clk,
    input  wire logic line_in,
    output var  logic line_out
);
    // idle high line, no handshake lines at all
    initial line_out = 1'b1;
    task automatic recv(output logic [7:0] b);
        while (line_in !== 1'b0) @(posedge clk);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge clk);
        if (line_in !== 1'b1) b = 8'hxx;
    endtask
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: test_scan_engine_host_control.sv */
// self-checking bench for the scan engine host control block
`timescale 1ns/1ps
`default_nettype none
module test_scan_engine_host_control import scan_engine_pkg::*;;
    localparam int TRIG = 20;
    localparam int GOOD = 50;
    localparam int GAP  = 5 * TRIG;
    localparam int BIT  = CLK_KHZ * 1000 / 115200;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        scan_trigger_n = 1'b1, wake_n = 1'b1, decode_good = 1'b0;
    logic        scan_active, scan_abort, serial_rx, serial_tx, low_power_flag_out;
    logic        beeper_pwm_out, good_read_out, irq;
    logic [7:0]  reg_addr = 8'h00, b;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    int          miscompares = 0, checked = 0, cyc = 0, n;

    scan_engine_host_control #(.TRIG_MIN_CYC_P(CNT_W'(TRIG)), .GOOD_READ_CYC_P(CNT_W'(GOOD)),
        .BEEP_CYC_P(CNT_W'(40000))) scan_engine_host_control_i (.clk, .rst_n, .ce, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scan_trigger_n, .wake_n, .decode_good,
        .scan_active, .scan_abort, .serial_rx, .serial_tx, .low_power_flag_out,
        .beeper_pwm_out, .good_read_out, .irq);
    host_uart_model #(.BIT_CYC(BIT)) host_uart_model_i (.clk, .line_in(serial_tx),
        .line_out(serial_rx));

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask
    // waits for a session to start and checks the qualifying low time
    task automatic start_chk();
        for (n = 0; n < 40 && scan_active !== 1'b1; n++) @(posedge clk);
        chk(32'(n >= TRIG && n <= TRIG + 4), 32'h0000_0001);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(ADDR_CTRL, d);
        chk(32'(d[2:0]), 32'h0000_0003);
        rd(8'h18, d);
        chk(d, 32'h0000_0000);
        scan_trigger_n <= 1'b0;
        start_chk();
        decode_good <= 1'b1;
        @(posedge clk);
        decode_good <= 1'b0;
        for (n = 0; n < 5 && good_read_out !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 80 && good_read_out === 1'b1; n++) @(posedge clk);
        chk(32'(n), 32'(GOOD));
        rd(ADDR_STATUS, d);
        chk(32'(d[3:0]), 32'h0000_0004);
        repeat (40) @(posedge clk);
        chk(32'(scan_active), 32'h0000_0000);
        scan_trigger_n <= 1'b1;
        repeat (GAP) @(posedge clk);
        wake_n <= 1'b0;
        start_chk();
        wake_n <= 1'b1;
        for (n = 0; n < 8 && scan_abort !== 1'b1; n++) @(posedge clk);
        chk(32'(n < 8), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        wr(ADDR_IRQ_STAT, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0007);
        wr(ADDR_TXDATA, 32'h0000_00A5);
        host_uart_model_i.recv(b);
        chk(32'(b), 32'h0000_00A5);
        host_uart_model_i.send(8'h3C);
        repeat (20) @(posedge clk);
        rd(ADDR_RXDATA, d);
        chk(d, 32'h0000_003C);
        rd(ADDR_IRQ_STAT, d);
        chk(d, 32'h0000_000B);
        // power-up tone goes high one half period after reset release
        for (n = 0; n < 4000 && beeper_pwm_out !== 1'b1; n++) @(posedge clk);
        chk(32'(cyc >= BEEP_HALF_CYC && cyc <= BEEP_HALF_CYC + 12), 32'h0000_0001);
        repeat (GAP) @(posedge clk);
        wr(ADDR_CTRL, 32'h0000_000F);
        repeat (2) @(posedge clk);
        chk(32'(low_power_flag_out), 32'h0000_0001);
        scan_trigger_n <= 1'b0;
        repeat (TRIG + 8) @(posedge clk);
        chk(32'(low_power_flag_out), 32'h0000_0000);
        scan_trigger_n <= 1'b1;
        repeat (10) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
